//--- design/bsc_csr_bank.sv
// boost and receive-sensitivity register bank with strap loading and serial access
// assumes: strap and bus pins are asynchronous; one 125 MHz clock; rstn is the device reset
`timescale 1ns/1ps
`include "bsc_regs.svh"
module bsc_csr_bank #(
  parameter logic [3:0] EDGE_RSVD = 4'h0,
  parameter logic [6:0] CFG_RSVD = 7'h00,
  parameter logic [3:0] STATIC_RSVD = 4'h0
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] boost_strap,
  input wire bsc_pkg::bsc_rx_strap_t rx_strap,
  output logic [3:0] edge_gain_level,
  output logic [3:0] static_gain_level,
  output logic [7:0] receive_sensitivity_level,
  output logic detect_halt,
  output logic detect_restart,
  output logic serial_enabled
);
  import bsc_pkg::*;

  localparam int STRAP_CYCLES = `BSC_STRAP_CYCLES;
  localparam logic [7:0] STRAP_LAST = 8'(STRAP_CYCLES - 1);

  function automatic logic [3:0] edge_code(input logic [1:0] lvl);
    unique case (lvl)
      2'h0: edge_code = `BSC_EDGE_L0;
      2'h1: edge_code = `BSC_EDGE_L1;
      2'h2: edge_code = `BSC_EDGE_L2;
      default: edge_code = `BSC_EDGE_L3;
    endcase
  endfunction

  function automatic logic [3:0] static_code(input logic [1:0] lvl);
    unique case (lvl)
      2'h0: static_code = `BSC_STATIC_L0;
      2'h1, 2'h2: static_code = `BSC_STATIC_L12;
      default: static_code = `BSC_STATIC_L3;
    endcase
  endfunction

  function automatic logic [7:0] rx_code(input bsc_rx_strap_t lvl);
    unique case (lvl)
      BSC_RX_LOW: rx_code = `BSC_RX_CODE_LOW;
      BSC_RX_MID: rx_code = `BSC_RX_CODE_MID;
      default: rx_code = `BSC_RX_CODE_HIGH;
    endcase
  endfunction

  bsc_reg_if rif ();

  logic scl_m, scl_s, sda_m, sda_s;
  logic [1:0] boost_m, boost_s;
  bsc_rx_strap_t rx_m, rx_s;
  bsc_boot_t boot, next_boot;
  logic [7:0] cnt, next_cnt;
  logic [7:0] edge_reg, cfg_reg, static_reg, rx_reg;
  logic [7:0] next_edge, next_cfg, next_static, next_rx;
  logic next_serial, next_restart;

  // pin synchronisers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      boost_m <= 2'h0;
      boost_s <= 2'h0;
      rx_m <= BSC_RX_LOW;
      rx_s <= BSC_RX_LOW;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
      boost_m <= boost_strap;
      boost_s <= boost_m;
      rx_m <= rx_strap;
      rx_s <= rx_m;
    end
  end

  bsc_i2c_slave u_port (
    .clock(clock),
    .rstn(rstn),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .port_en(serial_enabled),
    .sda_oe(sda_oe),
    .bus(rif.port)
  );

  // read mux, unmapped offsets read zero
  always_comb begin
    unique case (rif.addr)
      `BSC_OFS_EDGE: rif.rdata = edge_reg;
      `BSC_OFS_CFG: rif.rdata = cfg_reg;
      `BSC_OFS_STATIC: rif.rdata = static_reg;
      `BSC_OFS_RXSEN: rif.rdata = rx_reg;
      default: rif.rdata = 8'h00;
    endcase
  end

  // startup strap capture and host writes
  always_comb begin
    next_boot = boot;
    next_cnt = cnt;
    next_edge = edge_reg;
    next_cfg = cfg_reg;
    next_static = static_reg;
    next_rx = rx_reg;
    next_serial = serial_enabled;
    unique case (boot)
      BSC_BOOT_WAIT: begin
        next_cnt = cnt + 8'h01;
        if (cnt == STRAP_LAST) begin
          next_boot = BSC_BOOT_LOAD;
        end
      end
      BSC_BOOT_LOAD: begin
        next_edge[`BSC_EDGE_HI:`BSC_EDGE_LO] = edge_code(boost_s);
        next_static[`BSC_STATIC_HI:`BSC_STATIC_LO] = static_code(boost_s);
        next_rx = rx_code(rx_s);
        next_serial = scl_s & sda_s;
        next_boot = BSC_BOOT_RUN;
      end
      BSC_BOOT_RUN: begin
        if (rif.wr_en) begin
          unique case (rif.addr)
            `BSC_OFS_EDGE: next_edge = rif.wdata;
            `BSC_OFS_CFG: next_cfg = rif.wdata;
            `BSC_OFS_STATIC: next_static = rif.wdata;
            `BSC_OFS_RXSEN: next_rx = rif.wdata;
            default: begin
            end
          endcase
        end
      end
    endcase
    next_restart = cfg_reg[`BSC_CFG_BIT] & ~next_cfg[`BSC_CFG_BIT];
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      boot <= BSC_BOOT_WAIT;
      cnt <= 8'h00;
      edge_reg <= {`BSC_EDGE_L0, EDGE_RSVD};
      cfg_reg <= {CFG_RSVD, `BSC_CFG_RESET};
      static_reg <= {STATIC_RSVD, `BSC_STATIC_L0};
      rx_reg <= `BSC_RX_CODE_LOW;
      serial_enabled <= 1'b0;
      detect_restart <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      boot <= next_boot;
      cnt <= next_cnt;
      edge_reg <= next_edge;
      cfg_reg <= next_cfg;
      static_reg <= next_static;
      rx_reg <= next_rx;
      serial_enabled <= next_serial;
      detect_restart <= next_restart;
      sda_out <= 1'b0;
    end
  end

  assign edge_gain_level = edge_reg[`BSC_EDGE_HI:`BSC_EDGE_LO];
  assign static_gain_level = static_reg[`BSC_STATIC_HI:`BSC_STATIC_LO];
  assign receive_sensitivity_level = rx_reg;
  assign detect_halt = cfg_reg[`BSC_CFG_BIT];

  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rstn);

  chk_edge_strap_load: assert property (boot == BSC_BOOT_LOAD |=>
    edge_gain_level == edge_code($past(boost_s)))
    else $error("edge gain not loaded from strap");
  chk_static_strap_load: assert property (boot == BSC_BOOT_LOAD |=>
    static_gain_level == static_code($past(boost_s)))
    else $error("static gain not loaded from strap");
  chk_rx_strap_load: assert property (boot == BSC_BOOT_LOAD |=>
    receive_sensitivity_level == rx_code($past(rx_s)))
    else $error("sensitivity not loaded from strap");
  chk_cfg_reset_one: assert property (boot != BSC_BOOT_RUN |-> detect_halt)
    else $error("configuration flag not set after reset");
  chk_rsvd_reset_value: assert property (boot != BSC_BOOT_RUN |->
    edge_reg[3:0] == EDGE_RSVD && cfg_reg[7:1] == CFG_RSVD && static_reg[7:4] == STATIC_RSVD)
    else $error("reserved bits lost their reset value");
  chk_serial_start_gate: assert property (boot == BSC_BOOT_LOAD ##1 1'b1 |->
    serial_enabled == $past(scl_s & sda_s))
    else $error("serial enable not taken from line levels");
  chk_host_edge_write: assert property (boot == BSC_BOOT_RUN && rif.wr_en && rif.addr == `BSC_OFS_EDGE |=>
    edge_reg == $past(rif.wdata))
    else $error("host write to edge gain lost");
  chk_restart_pulse: assert property ($fell(detect_halt) |-> detect_restart ##1 !detect_restart)
    else $error("no single restart pulse on leaving configuration");
  chk_strap_wait_len: assert property ($rose(boot == BSC_BOOT_LOAD) |-> $past(cnt) == STRAP_LAST)
    else $error("strap sample delay wrong");

  cov_strap_load: cover property (boot == BSC_BOOT_LOAD ##1 serial_enabled);
  cov_host_write: cover property (rif.wr_en && rif.addr == `BSC_OFS_STATIC);
  cov_restart: cover property (detect_restart);
endmodule

//--- design/bsc_regs.svh
// register offsets, field positions, strap codes and timing for the boost/sensitivity bank
// assumes: included by bare name into design files that need the constants
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH

`define BSC_OFS_EDGE 8'h01
`define BSC_OFS_CFG 8'h03
`define BSC_OFS_STATIC 8'h0e
`define BSC_OFS_RXSEN 8'h25

`define BSC_DEV_ADDR 7'h2c

`define BSC_EDGE_HI 7
`define BSC_EDGE_LO 4
`define BSC_STATIC_HI 3
`define BSC_STATIC_LO 0
`define BSC_CFG_BIT 0
`define BSC_CFG_RESET 1'b1

`define BSC_EDGE_L0 4'h0
`define BSC_EDGE_L1 4'h3
`define BSC_EDGE_L2 4'h6
`define BSC_EDGE_L3 4'ha
`define BSC_STATIC_L0 4'h0
`define BSC_STATIC_L12 4'h2
`define BSC_STATIC_L3 4'h6
`define BSC_RX_CODE_LOW 8'h00
`define BSC_RX_CODE_MID 8'h33
`define BSC_RX_CODE_HIGH 8'h66

`define BSC_BYTE_BITS 4'h8
`define BSC_STRAP_DELAY_NS 1000
`define BSC_CLK_MHZ 125
`define BSC_STRAP_CYCLES ((`BSC_STRAP_DELAY_NS * `BSC_CLK_MHZ + 999) / 1000)

`endif

//--- design/bsc_pkg.sv
// types shared by the boost/sensitivity register bank and its serial port
// assumes: compiled before every other design file
package bsc_pkg;
  typedef logic [7:0] bsc_byte_t;
  typedef enum logic [1:0] {
    BSC_RX_LOW = 2'h0,
    BSC_RX_MID = 2'h1,
    BSC_RX_HIGH = 2'h2
  } bsc_rx_strap_t;
  typedef enum logic [2:0] {
    BSC_BOOT_WAIT = 3'h1,
    BSC_BOOT_LOAD = 3'h2,
    BSC_BOOT_RUN = 3'h4
  } bsc_boot_t;
  typedef enum logic [4:0] {
    BSC_SER_IDLE = 5'h01,
    BSC_SER_RECV = 5'h02,
    BSC_SER_ACK = 5'h04,
    BSC_SER_SEND = 5'h08,
    BSC_SER_MACK = 5'h10
  } bsc_ser_t;
endpackage

//--- design/bsc_reg_if.sv
// register access path between the serial port and the register bank
// assumes: one clock; wr_en is a one-cycle pulse, rdata is combinational from addr
`timescale 1ns/1ps
interface bsc_reg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport port (output wr_en, output addr, output wdata, input rdata);
  modport bank (input wr_en, input addr, input wdata, output rdata);
endinterface

//--- design/bsc_i2c_slave.sv
// two-wire standard-mode target: address match, register pointer, auto-increment reads and writes
// assumes: scl_s and sda_s already synchronised; sda_oe high pulls the data line low
`timescale 1ns/1ps
`include "bsc_regs.svh"
module bsc_i2c_slave (
  input wire logic clock,
  input wire logic rstn,
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic port_en,
  output logic sda_oe,
  bsc_reg_if.port bus
);
  import bsc_pkg::*;

  bsc_ser_t state, next_state;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] sr, next_sr, ptr, next_ptr;
  logic first, next_first, ptr_pend, next_ptr_pend, inc_pend, next_inc_pend;
  logic rw, next_rw, scl_q, sda_q, next_oe, wr, next_wr;
  logic rise, fall, start, stop;

  assign rise = scl_s & ~scl_q;
  assign fall = ~scl_s & scl_q;
  assign start = scl_s & scl_q & sda_q & ~sda_s;
  assign stop = scl_s & scl_q & ~sda_q & sda_s;
  assign bus.wr_en = wr;
  assign bus.addr = ptr;
  assign bus.wdata = sr;

  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_sr = sr;
    next_ptr = ptr;
    next_first = first;
    next_ptr_pend = ptr_pend;
    next_inc_pend = inc_pend;
    next_rw = rw;
    next_oe = sda_oe;
    next_wr = 1'b0;
    if (!port_en) begin
      next_state = BSC_SER_IDLE;
      next_oe = 1'b0;
    end else if (start) begin
      next_state = BSC_SER_RECV;
      next_bitcnt = 4'h0;
      next_first = 1'b1;
      next_oe = 1'b0;
    end else if (stop) begin
      next_state = BSC_SER_IDLE;
      next_oe = 1'b0;
    end else begin
      unique case (state)
        BSC_SER_IDLE: begin
        end
        BSC_SER_RECV: begin
          if (rise) begin
            next_sr = {sr[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end else if (fall && bitcnt == `BSC_BYTE_BITS) begin
            next_state = BSC_SER_ACK;
            next_oe = 1'b1;
            next_inc_pend = 1'b0;
            if (first) begin
              next_first = 1'b0;
              next_rw = sr[0];
              next_ptr_pend = ~sr[0];
              if (sr[7:1] != `BSC_DEV_ADDR) begin
                next_state = BSC_SER_IDLE;
                next_oe = 1'b0;
              end
            end else if (ptr_pend) begin
              next_ptr = sr;
              next_ptr_pend = 1'b0;
            end else begin
              next_wr = 1'b1;
              next_inc_pend = 1'b1;
            end
          end
        end
        BSC_SER_ACK: begin
          if (fall) begin
            if (rw) begin
              next_sr = bus.rdata;
              next_oe = ~bus.rdata[7];
              next_ptr = ptr + 8'h01;
              next_bitcnt = 4'h1;
              next_state = BSC_SER_SEND;
            end else begin
              next_oe = 1'b0;
              next_bitcnt = 4'h0;
              next_state = BSC_SER_RECV;
              if (inc_pend) begin
                next_ptr = ptr + 8'h01;
              end
            end
          end
        end
        BSC_SER_SEND: begin
          if (fall) begin
            if (bitcnt == `BSC_BYTE_BITS) begin
              next_oe = 1'b0;
              next_state = BSC_SER_MACK;
            end else begin
              next_oe = ~sr[6];
              next_sr = {sr[6:0], 1'b0};
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        BSC_SER_MACK: begin
          if (rise) begin
            next_state = sda_s ? BSC_SER_IDLE : BSC_SER_ACK;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= BSC_SER_IDLE;
      bitcnt <= 4'h0;
      sr <= 8'h00;
      ptr <= 8'h00;
      first <= 1'b0;
      ptr_pend <= 1'b0;
      inc_pend <= 1'b0;
      rw <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_oe <= 1'b0;
      wr <= 1'b0;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      sr <= next_sr;
      ptr <= next_ptr;
      first <= next_first;
      ptr_pend <= next_ptr_pend;
      inc_pend <= next_inc_pend;
      rw <= next_rw;
      scl_q <= scl_s;
      sda_q <= sda_s;
      sda_oe <= next_oe;
      wr <= next_wr;
    end
  end

  chk_addr_miss_release: assert property (@(posedge clock) disable iff (!rstn)
    (state == BSC_SER_RECV && fall && bitcnt == `BSC_BYTE_BITS && first && !start && !stop && port_en
     && sr[7:1] != `BSC_DEV_ADDR) |=> !sda_oe && state == BSC_SER_IDLE)
    else $error("foreign address was acknowledged");
  chk_write_only_enabled: assert property (@(posedge clock) disable iff (!rstn)
    wr |-> $past(port_en))
    else $error("register write while serial port disabled");
  cov_read_byte: cover property (@(posedge clock) disable iff (!rstn)
    state == BSC_SER_SEND ##[1:1000] state == BSC_SER_MACK);
endmodule

//--- verification/bsc_i2c_master.sv
// two-wire controller model that configures the bank through its serial pins
// assumes: sda_line is the wired level with a pull-up; scl is never stretched by the target
`timescale 1ns/1ps
module bsc_i2c_master #(
  parameter int Q = 16,
  parameter logic [6:0] DEV = 7'h2c
) (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick();
    repeat (Q) @(posedge clock);
    #1;
  endtask
  // one bit slot; data moves only while the clock line is low
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    tick();
    scl = 1'b1;
    tick();
    r = sda_line;
    tick();
    scl = 1'b0;
    tick();
  endtask
  // start or repeated start: data falls while clock is high
  task automatic start();
    sda_low = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b0;
    tick();
  endtask
  // byte out msb first, ack taken in the ninth slot
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(last, r);
  endtask
  // pointer then one data byte; gives up when the address is not acknowledged
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    start();
    put({dev, 1'b0}, ok);
    if (ok) begin
      put(ptr, ok);
      put(d, ok);
    end
    stop();
  endtask
  // pointer, repeated start, n bytes acked by the controller except the last
  task automatic rd(input logic [7:0] ptr, input int n, output logic [31:0] q);
    logic ok;
    logic [7:0] d;
    q = 32'h0;
    start();
    put({DEV, 1'b0}, ok);
    put(ptr, ok);
    start();
    put({DEV, 1'b1}, ok);
    for (int i = 0; i < n; i++) begin
      get(i == n - 1, d);
      q = {q[23:0], d};
    end
    stop();
  endtask
endmodule

//--- verification/bsc_csr_bank_tb_top.sv
// self-checking bench for the boost/sensitivity register bank, driven through its serial pins
// assumes: the serial controller model stands on the data and clock lines
`timescale 1ns/1ps
module bsc_csr_bank_tb_top;
  import bsc_pkg::*;
  localparam logic [7:0] EDGE_EXP [4] = '{8'h00, 8'h03, 8'h06, 8'h0a};
  localparam logic [7:0] STATIC_EXP [4] = '{8'h00, 8'h02, 8'h02, 8'h06};
  localparam logic [7:0] SENS_EXP [4] = '{8'h00, 8'h33, 8'h66, 8'h66};
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] boost_strap = 2'h0;
  bsc_rx_strap_t rx_strap = BSC_RX_LOW;
  logic sda_hold = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic detect_halt;
  logic detect_restart;
  logic serial_enabled;
  logic [3:0] edge_lvl;
  logic [3:0] static_lvl;
  logic [7:0] sens_lvl;
  int fail_count = 0;
  int n_compared = 0;
  int restarts = 0;
  // wired line with pull-up: low when any party pulls
  wire sda_line = ~(sda_oe | sda_low | sda_hold);

  always #4 clock = ~clock;

  bsc_csr_bank dut (
    .clock(clock),
    .rstn(rstn),
    .scl_in(scl),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .boost_strap(boost_strap),
    .rx_strap(rx_strap),
    .edge_gain_level(edge_lvl),
    .static_gain_level(static_lvl),
    .receive_sensitivity_level(sens_lvl),
    .detect_halt(detect_halt),
    .detect_restart(detect_restart),
    .serial_enabled(serial_enabled)
  );

  bsc_i2c_master #(.Q(16), .DEV(7'h2c)) mst (
    .clock(clock),
    .sda_line(sda_line),
    .scl(scl),
    .sda_low(sda_low)
  );

  always @(posedge clock) begin
    if (detect_restart === 1'b1) restarts <= restarts + 1;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // reset with given straps, optionally holding the data line low across the strap sample
  task automatic do_reset(input logic [1:0] b, input logic [1:0] r, input logic hold);
    rstn = 1'b0;
    boost_strap = b;
    rx_strap = bsc_rx_strap_t'(r);
    sda_hold = hold;
    repeat (3) @(posedge clock);
    #1;
    check({7'h0, detect_halt}, 8'h01);
    rstn = 1'b1;
    repeat (130) @(posedge clock);
    #1;
    sda_hold = 1'b0;
  endtask

  initial begin
    logic ok;
    logic [31:0] q;
    logic [7:0] e;
    logic [7:0] c;
    logic [7:0] s;
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1:0], i[1:0], 1'b0);
      check({4'h0, edge_lvl}, EDGE_EXP[i]);
      check({4'h0, static_lvl}, STATIC_EXP[i]);
      check(sens_lvl, SENS_EXP[i]);
      check({7'h0, serial_enabled}, 8'h01);
      check({7'h0, detect_halt}, 8'h01);
    end
    mst.rd(8'h01, 3, q);
    e = q[23:16];
    c = q[7:0];
    check(e, 8'ha0);
    check(q[15:8], 8'h00);
    check(c, 8'h01);
    mst.rd(8'h0e, 1, q);
    s = q[7:0];
    check(s, 8'h06);
    mst.rd(8'h25, 1, q);
    check(q[7:0], 8'h66);
    mst.wr(7'h2c, 8'h01, {4'hf, e[3:0]}, ok);
    check({7'h0, ok}, 8'h01);
    check({4'h0, edge_lvl}, 8'h0f);
    mst.wr(7'h2c, 8'h0e, {s[7:4], 4'hf}, ok);
    check({4'h0, static_lvl}, 8'h0f);
    mst.wr(7'h2c, 8'h25, 8'hff, ok);
    check(sens_lvl, 8'hff);
    mst.wr(7'h2c, 8'h03, {c[7:1], 1'b0}, ok);
    check({7'h0, detect_halt}, 8'h00);
    check(restarts[7:0], 8'h01);
    mst.wr(7'h2c, 8'h03, {c[7:1], 1'b1}, ok);
    check({7'h0, detect_halt}, 8'h01);
    check(restarts[7:0], 8'h01);
    mst.rd(8'h01, 1, q);
    check(q[7:0], {4'hf, e[3:0]});
    mst.wr(7'h2d, 8'h01, 8'h00, ok);
    check({7'h0, ok}, 8'h00);
    check({4'h0, edge_lvl}, 8'h0f);
    do_reset(2'h0, 2'h0, 1'b1);
    check({7'h0, serial_enabled}, 8'h00);
    mst.wr(7'h2c, 8'h01, 8'hf0, ok);
    check({7'h0, ok}, 8'h00);
    check({4'h0, edge_lvl}, 8'h00);
    check({7'h0, sda_out}, 8'h00);
    test_done();
  end

  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    test_done();
  end
endmodule
